/* File: verilog/wave_shutdown_pkg.sv */
// package: register map, field layout and reset values of the shutdown control block
package wave_shutdown_pkg;
    // byte addresses on the AHB-Lite slave
    localparam logic [7:0] ADDR_CONTROL = 8'h00; // shutdown control register
    localparam logic [7:0] ADDR_SOURCE = 8'h04; // per-source shutdown enables
    localparam logic [7:0] ADDR_STATUS = 8'h08; // sticky event flags, cleared by read
    localparam logic [7:0] ADDR_MASK = 8'h0C; // interrupt mask
    localparam logic [7:0] ADDR_MISC = 8'h10; // module enable, polarity, dead-band
    // control register fields
    localparam int BIT_FLAG = 7;
    localparam int BIT_RESTART = 6;
    localparam int POS_LEVEL_BD = 4;
    localparam int POS_LEVEL_AC = 2;
    localparam logic [7:0] CONTROL_RESET = 8'h14;
    // misc register fields
    localparam int BIT_ENABLE = 0;
    localparam int POS_POLARITY = 4;
    localparam int POS_DEADBAND = 8;
    localparam int DEADBAND_WIDTH = 6;
    localparam int SOURCE_COUNT = 4;
    // status flag positions
    localparam int EV_SHUTDOWN = 0;
    localparam int EV_RESUME = 1;
    localparam int EVENT_COUNT = 2;
    // shutdown level encodings
    localparam logic [1:0] LEVEL_INACTIVE = 2'h0;
    localparam logic [1:0] LEVEL_TRISTATE = 2'h1;
    localparam logic [1:0] LEVEL_LOW = 2'h2;
    localparam logic [1:0] LEVEL_HIGH = 2'h3;
endpackage : wave_shutdown_pkg

/* File: verilog/shutdown_pin_stage.sv */
// one output pin stage: applies the shutdown level to one waveform output
`timescale 1ns/100ps
`default_nettype none
module shutdown_pin_stage (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic runData,
    input wire logic inShutdown,
    input wire logic deadDone,
    input wire logic polarity,
    input wire logic [1:0] level,
    output logic pinOut,
    output logic pinOe
);
    logic next_pinOut; // next driven level
    logic next_pinOe; // next enable

    // choose the level for this pin from the shutdown field
    always_comb begin
        next_pinOut = runData ^ polarity;
        next_pinOe = 1'b1;
        if (inShutdown) begin
            case (level)
                wave_shutdown_pkg::LEVEL_HIGH: next_pinOut = 1'b1; // see R3
                wave_shutdown_pkg::LEVEL_LOW: next_pinOut = 1'b0; // see R3
                wave_shutdown_pkg::LEVEL_TRISTATE: begin
                    next_pinOut = 1'b0;
                    next_pinOe = 1'b0; // see R4
                end
                default: begin
                    // inactive level only once the dead-band has run out
                    next_pinOut = deadDone ? polarity : (runData ^ polarity); // see R5
                end
            endcase
        end
    end

    // register the pin drive
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pinOut <= 1'b0;
            pinOe <= 1'b0;
        end else begin
            pinOut <= next_pinOut;
            pinOe <= next_pinOe;
        end
    end
endmodule : shutdown_pin_stage
`default_nettype wire

/* File: verilog/waveform_auto_shutdown_control.sv */
// top: auto-shutdown control with AHB-Lite registers and four output pins
// Notes on behaviour
// R1 - hardware sets flag on shutdown event
// R2 - auto-restart bit clears flag automatically
// R3 - field 11 high, 10 low
// R4 - field 01 tri-states outputs B and D
// R5 - field 00 inactive level after dead-band
// R6 - software flag write forces shutdown levels
// R7 - resume only at next data rising edge
// R8 - each source gated by its enable
// R9 - A/C field same encodings, pins A/C
`timescale 1ns/100ps
`default_nettype none
module waveform_auto_shutdown_control (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [3:0] shutdownSource,
    input wire logic waveData,
    output logic waveform_output_a,
    output logic waveform_output_a_oe,
    output logic waveform_output_b,
    output logic waveform_output_b_oe,
    output logic waveform_output_c,
    output logic waveform_output_c_oe,
    output logic waveform_output_d,
    output logic waveform_output_d_oe,
    output logic irq
);
    // register state
    logic shutdownFlag, next_shutdownFlag; // shutdown state in effect
    logic restartEnable, next_restartEnable; // auto-restart enable
    logic [1:0] shutdown_level_pair_bd, next_shutdown_level_pair_bd; // B/D level
    logic [1:0] shutdown_level_pair_ac, next_shutdown_level_pair_ac; // A/C level
    logic [3:0] sourceEnable, next_sourceEnable; // bit0 is shutdown_source0_enable
    logic [1:0] status, next_status; // sticky events
    logic [1:0] mask, next_mask; // interrupt mask
    logic moduleEnable, next_moduleEnable; // module enable
    logic [3:0] polarity, next_polarity; // output polarity a..d
    logic [5:0] deadBand, next_deadBand; // dead-band count in clocks
    // pin synchronisers
    logic [3:0] srcMeta, srcSync; // shutdown source sync
    logic dataMeta, dataSync, dataLast; // data input sync
    // output hold and dead-band
    logic holdOut, next_holdOut; // outputs held in shutdown
    logic [5:0] deadCount, next_deadCount; // dead-band timer
    // bus data phase
    logic phaseWrite, next_phaseWrite; // pending write
    logic phaseRead, next_phaseRead; // pending read
    logic [7:0] phaseAddr, next_phaseAddr; // latched address
    logic [31:0] next_hrdata; // read data
    logic eventHit; // an enabled source is active
    logic dataRise; // rising edge of data
    logic flagWrite; // software writes control register
    logic addrTake; // valid address phase

    // one wait state on reads: hrdata is registered from the latched address, so it
    // stands only in the cycle after the read's first data-phase cycle
    assign hreadyout = ~phaseRead;
    assign hresp = 1'b0; // always OKAY
    assign irq = |(status & mask);

    // two-flop sync of pins; nothing reads the first stage but the second
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            srcMeta <= 4'h0;
            srcSync <= 4'h0;
            dataMeta <= 1'b0;
            dataSync <= 1'b0;
            dataLast <= 1'b0;
        end else begin
            srcMeta <= shutdownSource;
            srcSync <= srcMeta;
            dataMeta <= waveData;
            dataSync <= dataMeta;
            dataLast <= dataSync;
        end
    end

    assign eventHit = |(srcSync & sourceEnable); // see R8
    assign dataRise = dataSync & ~dataLast;
    assign addrTake = hsel & hready & htrans[1];
    assign flagWrite = phaseWrite && (phaseAddr == wave_shutdown_pkg::ADDR_CONTROL);

    // register file, flag and bus next-state
    always_comb begin
        next_phaseWrite = addrTake & hwrite;
        next_phaseRead = addrTake & ~hwrite;
        next_phaseAddr = addrTake ? haddr : phaseAddr;
        next_restartEnable = restartEnable;
        next_shutdown_level_pair_bd = shutdown_level_pair_bd;
        next_shutdown_level_pair_ac = shutdown_level_pair_ac;
        next_sourceEnable = sourceEnable;
        next_mask = mask;
        next_moduleEnable = moduleEnable;
        next_polarity = polarity;
        next_deadBand = deadBand;
        next_shutdownFlag = shutdownFlag;
        next_status = status;
        next_hrdata = 32'h0000_0000;
        if (phaseWrite) begin
            if (phaseAddr == wave_shutdown_pkg::ADDR_CONTROL) begin
                next_shutdownFlag = hwdata[wave_shutdown_pkg::BIT_FLAG]; // see R6
                next_restartEnable = hwdata[wave_shutdown_pkg::BIT_RESTART]; // see R2
                next_shutdown_level_pair_bd = hwdata[wave_shutdown_pkg::POS_LEVEL_BD +: 2];
                next_shutdown_level_pair_ac = hwdata[wave_shutdown_pkg::POS_LEVEL_AC +: 2];
            end else if (phaseAddr == wave_shutdown_pkg::ADDR_SOURCE) begin
                next_sourceEnable = hwdata[3:0]; // see R8
            end else if (phaseAddr == wave_shutdown_pkg::ADDR_MASK) begin
                next_mask = hwdata[1:0];
            end else if (phaseAddr == wave_shutdown_pkg::ADDR_MISC) begin
                next_moduleEnable = hwdata[wave_shutdown_pkg::BIT_ENABLE];
                next_polarity = hwdata[wave_shutdown_pkg::POS_POLARITY +: 4];
                next_deadBand = hwdata[wave_shutdown_pkg::POS_DEADBAND +: 6];
            end
        end
        if (phaseRead) begin
            if (phaseAddr == wave_shutdown_pkg::ADDR_CONTROL) begin
                next_hrdata = {24'h00_0000, shutdownFlag, restartEnable,
                    shutdown_level_pair_bd, shutdown_level_pair_ac, 2'h0}; // see R1
            end else if (phaseAddr == wave_shutdown_pkg::ADDR_SOURCE) begin
                next_hrdata = {28'h000_0000, sourceEnable};
            end else if (phaseAddr == wave_shutdown_pkg::ADDR_STATUS) begin
                next_hrdata = {30'h0000_0000, status};
                next_status = 2'h0; // read clears
            end else if (phaseAddr == wave_shutdown_pkg::ADDR_MASK) begin
                next_hrdata = {30'h0000_0000, mask};
            end else if (phaseAddr == wave_shutdown_pkg::ADDR_MISC) begin
                next_hrdata = {18'h0_0000, deadBand, polarity, 3'h0, moduleEnable};
            end
        end
        // auto-restart drops the flag once the sources are quiet
        if (restartEnable && !eventHit && shutdownFlag && !flagWrite) begin
            next_shutdownFlag = 1'b0; // see R2
        end
        // a live event wins over any clear
        if (eventHit) begin
            next_shutdownFlag = 1'b1; // see R1
        end
        if (eventHit && !shutdownFlag) begin
            next_status[wave_shutdown_pkg::EV_SHUTDOWN] = 1'b1;
        end
        if (holdOut && !shutdownFlag && dataRise) begin
            next_status[wave_shutdown_pkg::EV_RESUME] = 1'b1;
        end
    end

    // output hold and dead-band timer
    always_comb begin
        next_holdOut = holdOut;
        next_deadCount = deadCount;
        if (shutdownFlag) begin
            next_holdOut = 1'b1;
        end else if (holdOut && dataRise) begin
            next_holdOut = 1'b0; // see R7
        end
        if (!holdOut) begin
            next_deadCount = deadBand;
        end else if (deadCount != 6'h00) begin
            next_deadCount = deadCount - 6'h01; // see R5
        end
    end

    // register all state
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            shutdownFlag <= 1'b0;
            restartEnable <= 1'b0;
            shutdown_level_pair_bd <=
                wave_shutdown_pkg::CONTROL_RESET[wave_shutdown_pkg::POS_LEVEL_BD +: 2];
            shutdown_level_pair_ac <=
                wave_shutdown_pkg::CONTROL_RESET[wave_shutdown_pkg::POS_LEVEL_AC +: 2];
            sourceEnable <= 4'h0;
            status <= 2'h0;
            mask <= 2'h0;
            moduleEnable <= 1'b0;
            polarity <= 4'h0;
            deadBand <= 6'h00;
            holdOut <= 1'b0;
            deadCount <= 6'h00;
            phaseWrite <= 1'b0;
            phaseRead <= 1'b0;
            phaseAddr <= 8'h00;
            hrdata <= 32'h0000_0000;
        end else begin
            shutdownFlag <= next_shutdownFlag;
            restartEnable <= next_restartEnable;
            shutdown_level_pair_bd <= next_shutdown_level_pair_bd;
            shutdown_level_pair_ac <= next_shutdown_level_pair_ac;
            sourceEnable <= next_sourceEnable;
            status <= next_status;
            mask <= next_mask;
            moduleEnable <= next_moduleEnable;
            polarity <= next_polarity;
            deadBand <= next_deadBand;
            holdOut <= next_holdOut;
            deadCount <= next_deadCount;
            phaseWrite <= next_phaseWrite;
            phaseRead <= next_phaseRead;
            phaseAddr <= next_phaseAddr;
            hrdata <= next_hrdata;
        end
    end

    // per-pin stages; pins a and c use the A/C field
    logic [3:0] pinOut, pinOe;
    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_pin
            shutdown_pin_stage u_pin (
                .clk(clk),
                .sys_rst(sys_rst),
                .runData(dataSync & moduleEnable),
                .inShutdown(holdOut | shutdownFlag),
                .deadDone(deadCount == 6'h00),
                .polarity(polarity[i]),
                .level((i % 2 == 0) ? shutdown_level_pair_ac : shutdown_level_pair_bd), // see R9
                .pinOut(pinOut[i]),
                .pinOe(pinOe[i])
            );
        end
    endgenerate
    assign waveform_output_a = pinOut[0];
    assign waveform_output_b = pinOut[1];
    assign waveform_output_c = pinOut[2];
    assign waveform_output_d = pinOut[3];
    assign waveform_output_a_oe = pinOe[0];
    assign waveform_output_b_oe = pinOe[1];
    assign waveform_output_c_oe = pinOe[2];
    assign waveform_output_d_oe = pinOe[3];

    // checks
    sequence srcSeen_s;
        |(srcSync & sourceEnable);
    endsequence
    flag_set_a: assert property (@(posedge clk) disable iff (sys_rst)
        srcSeen_s |=> shutdownFlag) else $error("flag not set by event"); // see R1
    source_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
        (srcSync != 4'h0 && (srcSync & sourceEnable) == 4'h0 && !shutdownFlag && !flagWrite)
        |=> !shutdownFlag) else $error("disabled source set flag"); // see R8
    restart_clr_a: assert property (@(posedge clk) disable iff (sys_rst)
        (restartEnable && shutdownFlag && !eventHit && !flagWrite) |=> !shutdownFlag)
        else $error("auto-restart failed"); // see R2
    hold_rise_a: assert property (@(posedge clk) disable iff (sys_rst)
        (holdOut && !shutdownFlag && !dataRise) |=> holdOut)
        else $error("hold released without rising edge"); // see R7
    high_level_a: assert property (@(posedge clk) disable iff (sys_rst)
        (shutdownFlag && shutdown_level_pair_bd == 2'h3) |=> waveform_output_b)
        else $error("B not high in shutdown"); // see R3
    low_level_a: assert property (@(posedge clk) disable iff (sys_rst)
        (shutdownFlag && shutdown_level_pair_bd == 2'h2) |=> !waveform_output_d)
        else $error("D not low in shutdown"); // see R3
    tristate_a: assert property (@(posedge clk) disable iff (sys_rst)
        (shutdownFlag && shutdown_level_pair_bd == 2'h1) |=> !waveform_output_b_oe)
        else $error("B driven in tri-state"); // see R4
    ac_high_a: assert property (@(posedge clk) disable iff (sys_rst)
        (shutdownFlag && shutdown_level_pair_ac == 2'h3) |=> waveform_output_a)
        else $error("A not high in shutdown"); // see R9
    sw_write_a: assert property (@(posedge clk) disable iff (sys_rst)
        (flagWrite && hwdata[7]) |=> shutdownFlag ##1 holdOut)
        else $error("software shutdown ignored"); // see R6
    inactive_a: assert property (@(posedge clk) disable iff (sys_rst)
        (holdOut && deadCount == 6'h00 && shutdown_level_pair_bd == 2'h0)
        |=> waveform_output_b == polarity[1]) else $error("B not inactive"); // see R5
endmodule : waveform_auto_shutdown_control
`default_nettype wire

/* File: sim/power_stage_model.sv */
// partner: external power stage loading the four waveform pins
`timescale 1ns/100ps
`default_nettype none
module power_stage_model (
    input wire logic [3:0] pinLevel, // pin levels a..d
    input wire logic [3:0] pinOe, // drive enables a..d
    output logic [3:0] gateLevel // level seen by each gate driver
);
    // gate inputs carry pull-downs, so a released pin reads low and never holds its last value
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            gateLevel[i] = pinOe[i] ? pinLevel[i] : 1'b0;
        end
    end
endmodule : power_stage_model
`default_nettype wire

/* File: sim/waveform_auto_shutdown_control_tb_top.sv */
// testbench: register and pin scenarios for the auto-shutdown control block
`timescale 1ns/100ps
`default_nettype none
module waveform_auto_shutdown_control_tb_top;
    logic clk = 1'b0; // 20 MHz
    logic sys_rst = 1'b1; // held for 12 cycles
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout; // also the bus hready
    logic hresp;
    logic [3:0] shutdownSource = 4'h0;
    logic waveData = 1'b0;
    logic [3:0] pinLevel; // a..d
    logic [3:0] pinOe; // a..d
    logic [3:0] gateLevel; // as the power stage sees it
    logic irq;
    logic [31:0] scratch; // discarded read data
    int errTotal = 0;
    int samplesChecked = 0;
    int cycleCount = 0;
    localparam logic [3:0] POL = 4'h6; // polarity used with the level table

    always #25 clk = ~clk;

    waveform_auto_shutdown_control i_dut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .shutdownSource(shutdownSource), .waveData(waveData),
        .waveform_output_a(pinLevel[0]), .waveform_output_a_oe(pinOe[0]),
        .waveform_output_b(pinLevel[1]), .waveform_output_b_oe(pinOe[1]),
        .waveform_output_c(pinLevel[2]), .waveform_output_c_oe(pinOe[2]),
        .waveform_output_d(pinLevel[3]), .waveform_output_d_oe(pinOe[3]), .irq(irq));

    power_stage_model i_stage (.pinLevel(pinLevel), .pinOe(pinOe), .gateLevel(gateLevel));

    // closing report, the single exit of the run
    task automatic printVerdict();
        $display("checks %0d mismatches %0d", samplesChecked, errTotal);
        if (errTotal == 0 && samplesChecked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : printVerdict

    // hang guard: the tests need well under 2000 cycles
    always @(posedge clk) begin
        cycleCount <= cycleCount + 1;
        if (cycleCount == 20000) begin
            $display("ERROR timeout expected finish seen hang");
            errTotal = errTotal + 1;
            printVerdict();
        end
    end

    task automatic compare(input string what, input logic [31:0] expv, input logic [31:0] got);
        samplesChecked = samplesChecked + 1;
        if (got !== expv) begin
            $display("ERROR %s expected %h seen %h", what, expv, got);
            errTotal = errTotal + 1;
        end
    endtask : compare

    // one single transfer; every wait ends on hready, never on a fixed count
    task automatic busCycle(input logic [7:0] a, input logic wr, input logic [31:0] d,
                            output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask : busCycle

    task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
        busCycle(a, 1'b1, d, scratch);
    endtask : regWrite

    task automatic checkReg(input string what, input logic [7:0] a, input logic [31:0] expv);
        logic [31:0] rd;
        busCycle(a, 1'b0, 32'h0, rd);
        compare(what, expv, rd);
        compare("hresp", 32'h0, {31'h0, hresp});
    endtask : checkReg

    // pins sampled mid-cycle, once registered outputs have settled
    task automatic checkPins(input string what, input logic [7:0] expv);
        @(negedge clk);
        compare(what, {24'h0, expv}, {24'h0, pinOe, gateLevel});
    endtask : checkPins

    task automatic checkIrq(input logic expv);
        @(negedge clk);
        compare("irq", {31'h0, expv}, {31'h0, irq});
    endtask : checkIrq

    task automatic waitCycles(input int n);
        repeat (n) @(posedge clk);
    endtask : waitCycles

    // expected {oe, level} for a..d; a and c follow the a/c field, b and d the b/d field
    function automatic logic [7:0] expPins(input logic [1:0] bd, input logic [1:0] ac);
        logic [3:0] oe;
        logic [3:0] lv;
        logic [1:0] enc;
        for (int k = 0; k < 4; k++) begin
            enc = (k % 2 == 0) ? ac : bd;
            oe[k] = (enc != wave_shutdown_pkg::LEVEL_TRISTATE);
            lv[k] = (enc == wave_shutdown_pkg::LEVEL_HIGH) ||
                    (enc == wave_shutdown_pkg::LEVEL_INACTIVE && POL[k]);
        end
        return {oe, lv};
    endfunction : expPins

    // main sequence
    initial begin
        waitCycles(12);
        sys_rst <= 1'b0;
        checkPins("pins after reset", 8'h00);
        checkReg("control reset", wave_shutdown_pkg::ADDR_CONTROL, 32'h14);
        checkReg("unmapped read", 8'h20, 32'h0);
        $display("test reset done");
        // every level encoding on both pairs, flag written with the module disabled
        regWrite(wave_shutdown_pkg::ADDR_MISC, 32'h0360);
        for (int i = 0; i < 4; i++) begin
            regWrite(wave_shutdown_pkg::ADDR_CONTROL, {24'h0, 2'b10, i[1:0], ~i[1:0], 2'b00});
            waitCycles(12);
            checkPins("shutdown levels", expPins(i[1:0], ~i[1:0]));
            regWrite(wave_shutdown_pkg::ADDR_CONTROL, 32'h14);
        end
        $display("test levels done");
        // resume only on a data rising edge after the flag clears
        regWrite(wave_shutdown_pkg::ADDR_MISC, 32'h00F1);
        waveData <= 1'b1;
        waitCycles(6);
        waveData <= 1'b0;
        waitCycles(6);
        checkPins("normal output", 8'hFF);
        regWrite(wave_shutdown_pkg::ADDR_CONTROL, 32'hA8);
        waitCycles(6);
        checkPins("forced low", 8'hF0);
        busCycle(wave_shutdown_pkg::ADDR_STATUS, 1'b0, 32'h0, scratch);
        regWrite(wave_shutdown_pkg::ADDR_CONTROL, 32'h28);
        waitCycles(10);
        checkPins("held after clear", 8'hF0);
        waveData <= 1'b1;
        waitCycles(6);
        waveData <= 1'b0;
        waitCycles(6);
        checkPins("resumed", 8'hFF);
        checkReg("resume event", wave_shutdown_pkg::ADDR_STATUS, 32'h2);
        $display("test resume done");
        // hardware sources, gating, auto-restart and interrupt
        regWrite(wave_shutdown_pkg::ADDR_SOURCE, 32'hE);
        regWrite(wave_shutdown_pkg::ADDR_MASK, 32'h1);
        shutdownSource <= 4'h1;
        waitCycles(8);
        checkReg("disabled source", wave_shutdown_pkg::ADDR_CONTROL, 32'h28);
        checkIrq(1'b0);
        regWrite(wave_shutdown_pkg::ADDR_SOURCE, 32'h1);
        waitCycles(8);
        checkReg("flag set", wave_shutdown_pkg::ADDR_CONTROL, 32'hA8);
        checkIrq(1'b1);
        checkPins("source shutdown", 8'hF0);
        shutdownSource <= 4'h0;
        waitCycles(8);
        checkReg("no restart", wave_shutdown_pkg::ADDR_CONTROL, 32'hA8);
        regWrite(wave_shutdown_pkg::ADDR_CONTROL, 32'h68);
        shutdownSource <= 4'h1;
        waitCycles(8);
        checkReg("flag held", wave_shutdown_pkg::ADDR_CONTROL, 32'hE8);
        shutdownSource <= 4'h0;
        waitCycles(8);
        checkReg("auto restart", wave_shutdown_pkg::ADDR_CONTROL, 32'h68);
        checkReg("status", wave_shutdown_pkg::ADDR_STATUS, 32'h1);
        waitCycles(2);
        checkIrq(1'b0);
        regWrite(wave_shutdown_pkg::ADDR_MASK, 32'h0);
        shutdownSource <= 4'h1;
        waitCycles(8);
        checkIrq(1'b0);
        shutdownSource <= 4'h0;
        waitCycles(8);
        checkReg("masked status", wave_shutdown_pkg::ADDR_STATUS, 32'h1);
        $display("test sources done");
        printVerdict();
    end
endmodule : waveform_auto_shutdown_control_tb_top
`default_nettype wire
